//--- hdl/fpec_ctrl.sv
// Flash program and erase controller: registers and operation sequencer
`timescale 1ns/1ps
module fpec_ctrl (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [11:0] i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    output logic      [31:0] o_reg_rdata,
    output logic             o_fl_req,
    output logic      [1:0]  o_fl_op,
    output logic      [19:0] o_fl_addr,
    output logic      [31:0] o_fl_wdata,
    input  wire logic [31:0] i_fl_rdata,
    input  wire logic        i_fl_done,
    input  wire logic        i_fl_fail,
    output logic      [1:0]  o_bank_busy,
    input  wire logic        i_sleep_req,
    output logic             o_sleep_ok,
    input  wire logic        i_deep_sleep_req,
    output logic             o_flash_off
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    fpec_pkg::fpec_state_t    state_q, state_d;
    fpec_pkg::fpec_op_t       op_q, op_d;
    logic [19:0]              addr_q, addr_d, fl_addr_q, fl_addr_d;
    logic [31:0]              data_q, data_d, fl_wdata_q, fl_wdata_d, rdata_q, rdata_d;
    logic [2:0]               cmd_q, cmd_d;
    logic                     bufop_q, bufop_d, req_q, req_d;
    logic [4:0]               idx_q, idx_d;
    logic [1:0]               busy_q, busy_d;
    logic [3:0]               raw_q, raw_d, mask_q, mask_d;
    logic                     sleep_ok_q, sleep_ok_d, off_q, off_d;
    logic [3:0]               ev_set, ev_clr;
    logic                     fin, buf_clr, buf_wr, val_wr, cmd_ok, cmd2_ok, can_start;
    logic [31:0]              buf_rd_reg, buf_rd_seq;
    logic [31:0]              valid;

    // True for a word-aligned offset inside the buffer window
    function automatic logic is_buf(input logic [11:0] a);
        is_buf = (a >= fpec_pkg::OFS_BUF_LO) && (a <= fpec_pkg::OFS_BUF_HI)
                 && (a[1:0] == 2'h0);
    endfunction : is_buf

    // ------------------------------------------------------------------
    // Write buffer
    // ------------------------------------------------------------------
    assign buf_wr = i_reg_wr && is_buf(i_reg_addr);
    assign val_wr = i_reg_wr && (i_reg_addr == fpec_pkg::OFS_BVAL);

    fpec_wbuf #(.WORDS(32)) u_wbuf (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_wr       (buf_wr),
        .i_widx     (i_reg_addr[6:2]),
        .i_wdata    (i_reg_wdata),
        .i_ridx_a   (i_reg_addr[6:2]),
        .o_rdata_a  (buf_rd_reg),
        .i_ridx_b   (idx_q),
        .o_rdata_b  (buf_rd_seq),
        .i_val_wr   (val_wr),
        .i_val_data (i_reg_wdata),
        .i_clr      (buf_clr),
        .o_valid    (valid)
    );

    // ------------------------------------------------------------------
    // Register writes, sequencer and read mux
    // ------------------------------------------------------------------
    assign can_start = (state_q == fpec_pkg::ST_IDLE) && !i_sleep_req
                       && !i_deep_sleep_req && !off_q;
    assign cmd_ok  = i_reg_wr && (i_reg_addr == fpec_pkg::OFS_CMD)
                     && (i_reg_wdata[31:16] == fpec_pkg::CMD_KEY) && can_start;
    assign cmd2_ok = i_reg_wr && (i_reg_addr == fpec_pkg::OFS_CMD2)
                     && (i_reg_wdata[31:16] == fpec_pkg::CMD_KEY) && can_start;

    // Next-state logic for the sequencer and writable registers
    always_comb begin
        state_d = state_q; op_d = op_q; addr_d = addr_q; data_d = data_q;
        fl_addr_d = fl_addr_q; fl_wdata_d = fl_wdata_q; cmd_d = cmd_q;
        bufop_d = bufop_q; req_d = req_q; idx_d = idx_q; busy_d = busy_q;
        mask_d = mask_q; ev_set = '0; ev_clr = '0; fin = 1'b0; buf_clr = 1'b0;
        if (i_reg_wr) begin
            case (i_reg_addr)
                fpec_pkg::OFS_ADDR: addr_d = i_reg_wdata[19:0];
                fpec_pkg::OFS_DATA: data_d = i_reg_wdata;
                fpec_pkg::OFS_MASK: mask_d = i_reg_wdata[3:0];
                fpec_pkg::OFS_MCLR: ev_clr = i_reg_wdata[3:0];
                default: ;
            endcase
        end
        case (state_q)
            fpec_pkg::ST_IDLE: begin
                if (cmd_ok && i_reg_wdata[fpec_pkg::CMD_WRITE_BIT]) begin
                    fl_addr_d  = addr_q & ~fpec_pkg::WORD_MASK;
                    fl_wdata_d = data_q;
                    cmd_d      = 3'h1;
                    busy_d     = addr_q[fpec_pkg::BANK_BIT] ? 2'h2 : 2'h1;
                    state_d    = fpec_pkg::ST_CHECK;
                end else if (cmd_ok && i_reg_wdata[fpec_pkg::CMD_ERASE_BIT]) begin
                    fl_addr_d = addr_q & ~fpec_pkg::PAGE_MASK;
                    cmd_d     = 3'h2;
                    op_d      = fpec_pkg::OP_PAGE;
                    req_d     = 1'b1;
                    busy_d    = addr_q[fpec_pkg::BANK_BIT] ? 2'h2 : 2'h1;
                    state_d   = fpec_pkg::ST_ERASE;
                end else if (cmd_ok && i_reg_wdata[fpec_pkg::CMD_WHOLE_ARRAY_ERASE_GO_BIT]) begin
                    cmd_d   = 3'h4;
                    op_d    = fpec_pkg::OP_MASS;
                    req_d   = 1'b1;
                    busy_d  = fpec_pkg::BANK_BOTH;
                    state_d = fpec_pkg::ST_ERASE;
                end else if (cmd2_ok && i_reg_wdata[fpec_pkg::CMD2_BUFFERED_WRITE_GO_BIT]) begin
                    cmd_d   = 3'h1;
                    bufop_d = 1'b1;
                    idx_d   = '0;
                    busy_d  = addr_q[fpec_pkg::BANK_BIT] ? 2'h2 : 2'h1;
                    state_d = fpec_pkg::ST_NEXT;
                end
            end
            fpec_pkg::ST_NEXT: begin
                if (valid[idx_q]) begin
                    fl_addr_d  = (addr_q & ~fpec_pkg::BLOCK_MASK) | {13'h0000, idx_q, 2'h0};
                    fl_wdata_d = buf_rd_seq;
                    state_d    = fpec_pkg::ST_CHECK;
                end else if (idx_q == fpec_pkg::LAST_IDX) begin
                    fin = 1'b1;
                end else begin
                    idx_d = idx_q + 5'h01;
                end
            end
            fpec_pkg::ST_CHECK: begin
                if (|(~i_fl_rdata & fl_wdata_q)) begin
                    ev_set[fpec_pkg::EV_INVD] = 1'b1;
                    fin = 1'b1;
                end else begin
                    op_d    = fpec_pkg::OP_PROG;
                    req_d   = 1'b1;
                    state_d = fpec_pkg::ST_PROG;
                end
            end
            fpec_pkg::ST_PROG, fpec_pkg::ST_ERASE: begin
                if (i_fl_done) begin
                    req_d = 1'b0;
                    if (i_fl_fail) begin
                        ev_set[(state_q == fpec_pkg::ST_PROG) ? fpec_pkg::EV_PROG_ERR
                                                              : fpec_pkg::EV_ERASE_ERR] = 1'b1;
                    end
                    if (bufop_q && !i_fl_fail && (idx_q != fpec_pkg::LAST_IDX)) begin
                        idx_d   = idx_q + 5'h01;
                        state_d = fpec_pkg::ST_NEXT;
                    end else begin
                        fin = 1'b1;
                    end
                end
            end
            default: state_d = fpec_pkg::ST_IDLE;
        endcase
        // Common end of every operation
        if (fin) begin
            state_d = fpec_pkg::ST_IDLE;
            cmd_d   = '0;
            busy_d  = '0;
            req_d   = 1'b0;
            buf_clr = bufop_q;
            bufop_d = 1'b0;
            ev_set[fpec_pkg::EV_DONE] = 1'b1;
        end
    end

    // Sticky events; a new event beats a clear in the same cycle
    assign raw_d      = (raw_q & ~ev_clr) | ev_set;
    assign sleep_ok_d = i_sleep_req && (state_q == fpec_pkg::ST_IDLE);
    assign off_d      = i_deep_sleep_req && (off_q || (state_q == fpec_pkg::ST_IDLE));

    // Read data mux, unmapped offsets read zero
    always_comb begin
        rdata_d = '0;
        if (i_reg_rd) begin
            case (i_reg_addr)
                fpec_pkg::OFS_ADDR: rdata_d = {12'h000, addr_q};
                fpec_pkg::OFS_DATA: rdata_d = data_q;
                fpec_pkg::OFS_CMD:  rdata_d = {29'h00000000, cmd_q};
                fpec_pkg::OFS_RAW:  rdata_d = {28'h0000000, raw_q};
                fpec_pkg::OFS_MASK: rdata_d = {28'h0000000, mask_q};
                fpec_pkg::OFS_MCLR: rdata_d = {28'h0000000, raw_q & mask_q};
                fpec_pkg::OFS_CMD2: rdata_d = {31'h00000000, bufop_q};
                fpec_pkg::OFS_BVAL: rdata_d = valid;
                default: rdata_d = is_buf(i_reg_addr) ? buf_rd_reg : 32'h00000000;
            endcase
        end
    end

    // Register update
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= fpec_pkg::ST_IDLE; op_q <= fpec_pkg::OP_PROG;
            addr_q <= '0; data_q <= '0; fl_addr_q <= '0; fl_wdata_q <= '0;
            rdata_q <= '0; cmd_q <= '0; bufop_q <= 1'b0; req_q <= 1'b0;
            idx_q <= '0; busy_q <= '0; raw_q <= '0; mask_q <= '0;
            sleep_ok_q <= 1'b0; off_q <= 1'b0;
        end else begin
            state_q <= state_d; op_q <= op_d;
            addr_q <= addr_d; data_q <= data_d; fl_addr_q <= fl_addr_d;
            fl_wdata_q <= fl_wdata_d; rdata_q <= rdata_d; cmd_q <= cmd_d;
            bufop_q <= bufop_d; req_q <= req_d; idx_q <= idx_d; busy_q <= busy_d;
            raw_q <= raw_d; mask_q <= mask_d; sleep_ok_q <= sleep_ok_d; off_q <= off_d;
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_fl_req    = req_q;
    assign o_fl_op     = op_q;
    assign o_fl_addr   = fl_addr_q;
    assign o_fl_wdata  = fl_wdata_q;
    assign o_bank_busy = busy_q;
    assign o_sleep_ok  = sleep_ok_q;
    assign o_flash_off = off_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_bank_held: assert property ((state_q != fpec_pkg::ST_IDLE) |-> (busy_q != 2'h0))
        else $error("bank not held during operation");
    a_inv_abort: assert property ((state_q == fpec_pkg::ST_CHECK && |(~i_fl_rdata & fl_wdata_q))
        |=> (!req_q && raw_q[fpec_pkg::EV_INVD] && state_q == fpec_pkg::ST_IDLE))
        else $error("zero to one program not aborted");
    a_cmd_busy: assert property ((state_q != fpec_pkg::ST_IDLE) |-> (cmd_q != 3'h0))
        else $error("command bit clear while busy");
    a_cmd_clears: assert property ((state_q != fpec_pkg::ST_IDLE ##1 state_q == fpec_pkg::ST_IDLE)
        |-> (cmd_q == 3'h0 && raw_q[fpec_pkg::EV_DONE]))
        else $error("completion not reported");
    a_page_only: assert property ((req_q && op_q == fpec_pkg::OP_PAGE)
        |-> ((fl_addr_q & fpec_pkg::PAGE_MASK) == 20'h00000))
        else $error("page erase address not page aligned");
    a_buf_map: assert property ((state_q == fpec_pkg::ST_PROG && bufop_q)
        |-> (fl_addr_q == ((addr_q & ~fpec_pkg::BLOCK_MASK) | {13'h0000, idx_q, 2'h0})))
        else $error("buffer word mapped to wrong address");
    a_buf_valid: assert property ((state_q == fpec_pkg::ST_CHECK && bufop_q) |-> valid[idx_q])
        else $error("unwritten buffer word programmed");
    a_bval_clear: assert property ((state_q == fpec_pkg::ST_NEXT && idx_q == fpec_pkg::LAST_IDX
        && !valid[idx_q] && !buf_wr && !val_wr) |=> (valid == 32'h00000000))
        else $error("updated bits kept after buffered write");
    a_key_check: assert property ((i_reg_wr && i_reg_addr == fpec_pkg::OFS_CMD
        && i_reg_wdata[31:16] != fpec_pkg::CMD_KEY && state_q == fpec_pkg::ST_IDLE)
        |=> (state_q == fpec_pkg::ST_IDLE && cmd_q == 3'h0))
        else $error("unkeyed command accepted");
    a_sleep_idle: assert property (o_sleep_ok |-> ($past(state_q) == fpec_pkg::ST_IDLE))
        else $error("sleep granted while busy");
    a_addr_upper: assert property ((i_reg_rd && i_reg_addr == fpec_pkg::OFS_ADDR)
        |=> (o_reg_rdata[31:20] == 12'h000))
        else $error("address upper bits not zero");

    c_word_write: cover property (state_q == fpec_pkg::ST_PROG && !bufop_q ##1 i_fl_done);
    c_page_erase: cover property (req_q && op_q == fpec_pkg::OP_PAGE);
    c_mass_erase: cover property (req_q && op_q == fpec_pkg::OP_MASS);
    c_buf_write:  cover property (bufop_q && state_q == fpec_pkg::ST_PROG);
endmodule : fpec_ctrl

//--- hdl/fpec_wbuf.sv
// Thirty-two word write buffer with per-word updated bits
`timescale 1ns/1ps
module fpec_wbuf #(
    parameter int unsigned WORDS = 32
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_n,
    input  wire logic                     i_wr,
    input  wire logic [$clog2(WORDS)-1:0] i_widx,
    input  wire logic [31:0]              i_wdata,
    input  wire logic [$clog2(WORDS)-1:0] i_ridx_a,
    output logic      [31:0]              o_rdata_a,
    input  wire logic [$clog2(WORDS)-1:0] i_ridx_b,
    output logic      [31:0]              o_rdata_b,
    input  wire logic                     i_val_wr,
    input  wire logic [WORDS-1:0]         i_val_data,
    input  wire logic                     i_clr,
    output logic      [WORDS-1:0]         o_valid
);
    logic [31:0]      mem_q [WORDS];
    logic [WORDS-1:0] val_q;
    logic [WORDS-1:0] val_d;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Data words, no reset needed
    always_ff @(posedge i_clk) begin
        if (i_wr) begin
            mem_q[i_widx] <= i_wdata;
        end
    end

    assign o_rdata_a = mem_q[i_ridx_a];
    assign o_rdata_b = mem_q[i_ridx_b];

    // Updated bits; a word write in the clearing cycle keeps its bit
    always_comb begin
        val_d = val_q;
        if (i_val_wr) begin
            val_d = i_val_data;
        end else if (i_clr) begin
            val_d = '0;
        end
        if (i_wr) begin
            val_d[i_widx] = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            val_q <= '0;
        end else begin
            val_q <= val_d;
        end
    end

    assign o_valid = val_q;
endmodule : fpec_wbuf

//--- shared/fpec_pkg.sv
// Shared constants and types for the flash program and erase controller
package fpec_pkg;
    // ------------------------------------------------------------------
    // Register offsets (byte offsets from the controller base)
    // ------------------------------------------------------------------
    localparam int unsigned    REG_AW          = 12;
    localparam logic [11:0]    OFS_ADDR        = 12'h000;
    localparam logic [11:0]    OFS_DATA        = 12'h004;
    localparam logic [11:0]    OFS_CMD         = 12'h008;
    localparam logic [11:0]    OFS_RAW         = 12'h00C;
    localparam logic [11:0]    OFS_MASK        = 12'h010;
    localparam logic [11:0]    OFS_MCLR        = 12'h014;
    localparam logic [11:0]    OFS_CMD2        = 12'h020;
    localparam logic [11:0]    OFS_BVAL        = 12'h030;
    localparam logic [11:0]    OFS_BUF_LO      = 12'h100;
    localparam logic [11:0]    OFS_BUF_HI      = 12'h17C;
    // ------------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------------
    localparam logic [15:0]    CMD_KEY         = 16'hA442;
    localparam int unsigned    CMD_WRITE_BIT   = 0;
    localparam int unsigned    CMD_ERASE_BIT   = 1;
    localparam int unsigned    CMD_WHOLE_ARRAY_ERASE_GO_BIT  = 2;
    localparam int unsigned    CMD2_BUFFERED_WRITE_GO_BIT  = 0;
    localparam int unsigned    EV_W            = 4;
    localparam int unsigned    EV_DONE         = 0;
    localparam int unsigned    EV_INVD         = 1;
    localparam int unsigned    EV_ERASE_ERR    = 2;
    localparam int unsigned    EV_PROG_ERR     = 3;
    localparam int unsigned    FADDR_W         = 20;
    localparam int unsigned    BANK_BIT        = 19;
    localparam logic [19:0]    WORD_MASK       = 20'h00003;
    localparam logic [19:0]    PAGE_MASK       = 20'h007FF;
    localparam logic [19:0]    BLOCK_MASK      = 20'h0007F;
    localparam logic [4:0]     LAST_IDX        = 5'h1F;
    localparam logic [1:0]     BANK_BOTH       = 2'h3;
    // ------------------------------------------------------------------
    // Sequencer states and array operations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CHECK = 3'b001,
        ST_PROG  = 3'b010,
        ST_ERASE = 3'b011,
        ST_NEXT  = 3'b100
    } fpec_state_t;
    typedef enum logic [1:0] {
        OP_PROG = 2'b00,
        OP_PAGE = 2'b01,
        OP_MASS = 2'b10
    } fpec_op_t;
endpackage : fpec_pkg

//--- testbench/fpec_ctrl_tb_top.sv
// Self-checking bench for the flash program and erase controller
`timescale 1ns/1ps
module fpec_ctrl_tb_top;
    logic        clk, rst_n, wr, rd, req, done, fail, slp, dslp, slp_ok, off, ffail;
    logic [11:0] addr;
    logic [31:0] wdata, rdata, fl_rd, fl_wd, v;
    logic [1:0]  op, busy;
    logic [19:0] fl_a;
    logic [3:0]  wt;
    int          failures, cmp_count;

    fpec_ctrl dut (.i_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_fl_req(req),
        .o_fl_op(op), .o_fl_addr(fl_a), .o_fl_wdata(fl_wd), .i_fl_rdata(fl_rd),
        .i_fl_done(done), .i_fl_fail(fail), .o_bank_busy(busy), .i_sleep_req(slp),
        .o_sleep_ok(slp_ok), .i_deep_sleep_req(dslp), .o_flash_off(off));
    fpec_flash_model fl (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_op(op),
        .i_addr(fl_a), .i_wdata(fl_wd), .i_wait(wt), .i_fail(ffail), .o_rdata(fl_rd),
        .o_done(done), .o_fail(fail));

    // Clock of 100 ns period
    always #50 clk = ~clk;

    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        @(negedge clk);
        wr    = 1'b1;
        addr  = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask : wreg
    task automatic rreg(input logic [11:0] a);
        @(negedge clk);
        rd   = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        v  = rdata;
    endtask : rreg
    task automatic poll;
        int n;
        n = 0;
        v = 32'h1;
        while (v !== 32'h0 && n < 200) begin
            rreg(fpec_pkg::OFS_CMD);
            n++;
        end
        check("cmd idle", v, 32'h0);
    endtask : poll
    task automatic s_regs;
        rreg(fpec_pkg::OFS_ADDR);
        check("addr rst", v, 32'h0);
        wreg(fpec_pkg::OFS_ADDR, 32'hFFFFFFFF);
        rreg(fpec_pkg::OFS_ADDR);
        check("addr", v, 32'h000FFFFF);
        wreg(fpec_pkg::OFS_DATA, 32'hA55A5AA5);
        rreg(fpec_pkg::OFS_DATA);
        check("data", v, 32'hA55A5AA5);
        wreg(12'h040, 32'h12345678);
        rreg(12'h040);
        check("unmapped", v, 32'h0);
        wreg(fpec_pkg::OFS_CMD, 32'h12340001);
        rreg(fpec_pkg::OFS_CMD);
        check("bad key", v, 32'h0);
    endtask : s_regs
    task automatic s_word;
        wreg(fpec_pkg::OFS_DATA, 32'h0F0F00FF);
        wreg(fpec_pkg::OFS_ADDR, 32'h00000100);
        wreg(fpec_pkg::OFS_CMD, 32'hA4420001);
        rreg(fpec_pkg::OFS_CMD);
        check("cmd busy", v, 32'h1);
        check("bank0", {30'h0, busy}, 32'h1);
        poll;
        check("word", fl.mem[18'h40], 32'h0F0F00FF);
        rreg(fpec_pkg::OFS_RAW);
        check("done", v, 32'h1);
        wreg(fpec_pkg::OFS_MCLR, 32'hF);
        wreg(fpec_pkg::OFS_DATA, 32'hFFFFFFFF);
        wreg(fpec_pkg::OFS_CMD, 32'hA4420001);
        poll;
        check("kept", fl.mem[18'h40], 32'h0F0F00FF);
        rreg(fpec_pkg::OFS_RAW);
        check("invalid", v, 32'h3);
        wreg(fpec_pkg::OFS_MCLR, 32'hF);
    endtask : s_word
    task automatic s_page;
        wreg(fpec_pkg::OFS_DATA, 32'h0);
        wreg(fpec_pkg::OFS_ADDR, 32'h00000800);
        wreg(fpec_pkg::OFS_CMD, 32'hA4420001);
        poll;
        wreg(fpec_pkg::OFS_ADDR, 32'h00000000);
        wreg(fpec_pkg::OFS_CMD, 32'hA4420002);
        rreg(fpec_pkg::OFS_CMD);
        check("erase busy", v, 32'h2);
        poll;
        check("erased", fl.mem[18'h40], 32'hFFFFFFFF);
        check("other page", fl.mem[18'h200], 32'h0);
    endtask : s_page
    task automatic s_buf;
        wreg(fpec_pkg::OFS_BUF_LO, 32'h11111111);
        wreg(fpec_pkg::OFS_BUF_LO + 12'h008, 32'h22222222);
        rreg(fpec_pkg::OFS_BVAL);
        check("updated", v, 32'h5);
        wreg(fpec_pkg::OFS_ADDR, 32'h00080000);
        wreg(fpec_pkg::OFS_CMD2, 32'hA4420001);
        rreg(fpec_pkg::OFS_CMD2);
        check("buf busy", v, 32'h1);
        check("bank1", {30'h0, busy}, 32'h2);
        poll;
        check("w0", fl.mem[18'h20000], 32'h11111111);
        check("w1", fl.mem[18'h20001], 32'hFFFFFFFF);
        check("w2", fl.mem[18'h20002], 32'h22222222);
        rreg(fpec_pkg::OFS_BVAL);
        check("upd clear", v, 32'h0);
        wreg(fpec_pkg::OFS_BVAL, 32'h80000000);
        rreg(fpec_pkg::OFS_BVAL);
        check("bval load", v, 32'h80000000);
    endtask : s_buf
    task automatic s_mass;
        wreg(fpec_pkg::OFS_CMD, 32'hA4420004);
        rreg(fpec_pkg::OFS_CMD);
        check("mass busy", v, 32'h4);
        check("banks", {30'h0, busy}, 32'h3);
        poll;
        check("mass", fl.mem[18'h20000], 32'hFFFFFFFF);
    endtask : s_mass
    task automatic s_sleep;
        wt = 4'hF;
        wreg(fpec_pkg::OFS_CMD, 32'hA4420002);
        slp = 1'b1;
        repeat (3) @(negedge clk);
        check("sleep held", {31'h0, slp_ok}, 32'h0);
        poll;
        check("sleep ok", {31'h0, slp_ok}, 32'h1);
        dslp = 1'b1;
        repeat (2) @(negedge clk);
        check("flash off", {31'h0, off}, 32'h1);
        wreg(fpec_pkg::OFS_CMD, 32'hA4420001);
        rreg(fpec_pkg::OFS_CMD);
        check("blocked", v, 32'h0);
    endtask : s_sleep
    task automatic s_fail;
        wreg(fpec_pkg::OFS_MCLR, 32'hF);
        ffail = 1'b1;
        wreg(fpec_pkg::OFS_CMD, 32'hA4420002);
        poll;
        rreg(fpec_pkg::OFS_RAW);
        check("erase err", v, 32'h5);
        wreg(fpec_pkg::OFS_MASK, 32'h4);
        rreg(fpec_pkg::OFS_MCLR);
        check("masked", v, 32'h4);
        wreg(fpec_pkg::OFS_MCLR, 32'hF);
        wreg(fpec_pkg::OFS_DATA, 32'h0);
        wreg(fpec_pkg::OFS_CMD, 32'hA4420001);
        poll;
        rreg(fpec_pkg::OFS_RAW);
        check("prog err", v, 32'h9);
        ffail = 1'b0;
        wreg(fpec_pkg::OFS_MCLR, 32'hF);
    endtask : s_fail
    task automatic s_reset;
        @(negedge clk);
        rst_n = 1'b0;
        slp   = 1'b0;
        dslp  = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        check("off rst", {31'h0, off}, 32'h0);
        rreg(fpec_pkg::OFS_RAW);
        check("raw rst", v, 32'h0);
        rreg(fpec_pkg::OFS_BVAL);
        check("bval rst", v, 32'h0);
    endtask : s_reset
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    // Reset, then the scenarios in order
    initial begin
        clk       = 1'b0;
        rst_n     = 1'b0;
        wr        = 1'b0;
        rd        = 1'b0;
        addr      = 12'h000;
        wdata     = 32'h0;
        slp       = 1'b0;
        dslp      = 1'b0;
        wt        = 4'h4;
        ffail     = 1'b0;
        failures  = 0;
        cmp_count = 0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        s_regs;
        s_word;
        s_page;
        s_buf;
        s_mass;
        s_fail;
        s_sleep;
        s_reset;
        end_of_test;
    end
    // Watchdog, far beyond the expected few hundred cycles
    initial begin
        #3000000;
        failures++;
        end_of_test;
    end
endmodule : fpec_ctrl_tb_top

//--- testbench/fpec_flash_model.sv
// Behavioural flash array, erased words read as all ones
`timescale 1ns/1ps
module fpec_flash_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_req,
    input  wire logic [1:0]  i_op,
    input  wire logic [19:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wait,
    input  wire logic        i_fail,
    output logic      [31:0] o_rdata,
    output logic             o_done,
    output logic             o_fail
);
    logic [31:0] mem [0:262143];
    logic [3:0]  cnt_q;
    // Word under the requested address, always driven
    assign o_rdata = mem[i_addr[19:2]];
    // Failure is reported with the done pulse and leaves the array alone
    assign o_fail  = o_done & i_fail;
    initial begin
        for (int k = 0; k < 262144; k++) mem[k] = 32'hFFFFFFFF;
    end
    // Finish each request after i_wait extra cycles
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_done <= 1'b0;
            cnt_q  <= 4'h0;
        end else begin
            o_done <= 1'b0;
            if (i_req && !o_done) begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == i_wait) begin
                    o_done <= 1'b1;
                    cnt_q  <= 4'h0;
                    if (i_op == 2'h0 && !i_fail) begin
                        mem[i_addr[19:2]] <= mem[i_addr[19:2]] & i_wdata;
                    end
                    if (i_op == 2'h1 && !i_fail) begin
                        for (int k = 0; k < 512; k++) mem[{i_addr[19:11], k[8:0]}] <= '1;
                    end
                    if (i_op == 2'h2 && !i_fail) begin
                        for (int k = 0; k < 262144; k++) mem[k] <= 32'hFFFFFFFF;
                    end
                end
            end
        end
    end
endmodule : fpec_flash_model
